// ### src/ccglue_top.sv
// Processor card glue logic: decode, bus error, interrupts, refresh, power fail.
`timescale 1ns/1ps
// Summary of operation
// - Decode processor address into strobes and selects for backplane, SRAM, boot ROM.
// - Acknowledge every decoded target locally except backplane, whose acknowledge passes through.
// - Bus-error timer counts while address strobe asserted, clears on negation.
// - Strobe held past timeout asserts bus error to the processor.
// - Interrupt sources encode into one priority level on processor inputs.
// - Power-fail warning tells other cards a system reset will follow.
// - Warning is driven from one bit of a processor-writable output latch.
// - Processor asserts warning on a serious system error by setting the bit.
// - Backplane chip watchdog failure also asserts the warning.
// - Periodic timer interrupts the processor every 3.2768 ms for refresh.
// - Write to the refresh address is decoded as a DRAM refresh cycle.
// - SRAM decode gives one 32-bit bank select and four byte-wide selects.
// - During power fail all processor accesses to buffered SRAM are blocked.
// - Card self-test runs after every system reset.
// - Warning line is open-drain so the power converter may also drive it.
module ccglue_top #(
	parameter int unsigned BERR_TIMEOUT = ccglue_pkg::BERR_CYCLES,
	parameter int unsigned REFRESH_PER  = ccglue_pkg::REFRESH_CYCLES,
	parameter int unsigned TEST_LEN     = ccglue_pkg::SELFTEST_CYCLES,
	parameter int unsigned IRQ_N        = 6
) (
	// Clock and reset
	input  wire logic             clk_i,
	input  wire logic             reset_n_i,
	// Processor bus
	input  wire logic [31:0]      addr_i,
	input  wire logic [7:0]       wdata_i,
	input  wire logic             as_n_i,
	input  wire logic             ds_n_i,
	input  wire logic             rw_i,
	output logic                  dsack_n_o,
	output logic                  berr_n_o,
	output logic [2:0]            ipl_n_o,
	// Interrupt sources, index is level minus one
	input  wire logic [IRQ_N-1:0] irq_i,
	// Backplane bus interface chip
	output logic                  back_cs_n_o,
	output logic                  back_strb_n_o,
	input  wire logic             back_ack_n_i,
	input  wire logic             back_wdog_fail_i,
	// Memories
	output logic                  boot_cs_n_o,
	output logic                  sram32_cs_n_o,
	output logic [3:0]            sram8_cs_n_o,
	output logic                  mem_oe_n_o,
	output logic                  mem_we_n_o,
	output logic                  dram_refresh_o,
	// Power-fail warning, open drain
	input  wire logic             power_fail_warning_i,
	output logic                  power_fail_warning_o,
	output logic                  power_fail_warning_oe_n_o,
	// Self-test status
	output logic                  self_test_busy_o
);

	// ----------------------------------------
	// Address decode
	// ----------------------------------------
	wire       as_act   = !as_n_i;
	wire [3:0] region   = addr_i[31:28];
	wire       pf_now;
	wire       hit_boot = as_act && (region == ccglue_pkg::REG_BOOT);
	wire       hit_s32  = as_act && (region == ccglue_pkg::REG_SRAM32) && !pf_now;
	wire       hit_s8   = as_act && (region == ccglue_pkg::REG_SRAM8) && !pf_now;
	wire       hit_back = as_act && (region == ccglue_pkg::REG_BACK);
	wire       hit_io   = as_act && (region == ccglue_pkg::REG_IO);
	wire       wr_strb  = !ds_n_i && !rw_i;
	wire       hit_lat  = hit_io && (addr_i[27:0] == ccglue_pkg::IO_LATCH);
	wire       hit_ref  = hit_io && (addr_i[27:0] == ccglue_pkg::IO_REFRESH);
	wire [1:0] bank_sel = addr_i[ccglue_pkg::BANK_LSB +: 2];

	// Chip selects and strobes.
	assign boot_cs_n_o   = !hit_boot;
	assign sram32_cs_n_o = !hit_s32;
	assign back_cs_n_o   = !hit_back;
	assign back_strb_n_o = !(hit_back && !ds_n_i);
	assign mem_oe_n_o    = !(as_act && rw_i && !ds_n_i);
	assign mem_we_n_o    = !(as_act && wr_strb);

	// One select per byte-wide bank.
	genvar g;
	generate
		for (g = 0; g < 4; g++)
		begin : g_bank
			assign sram8_cs_n_o[g] = !(hit_s8 && (bank_sel == 2'(g)));
		end
	endgenerate

	// Local acknowledge or pass-through of the backplane acknowledge.
	wire local_hit = hit_boot || hit_s32 || hit_s8 || hit_lat || hit_ref;
	assign dsack_n_o = hit_back ? back_ack_n_i : !(local_hit && !ds_n_i);

	// ----------------------------------------
	// Bus-error watchdog
	// ----------------------------------------
	logic [31:0] berr_cnt_reg;
	logic [31:0] berr_cnt_next;
	logic        berr_reg;
	logic        berr_next;
	wire         berr_hit = (berr_cnt_reg >= 32'(BERR_TIMEOUT));

	// Count while strobe held, clear on negation.
	assign berr_cnt_next = !as_act ? 32'h00000000 : (berr_hit ? berr_cnt_reg : berr_cnt_reg + 32'h00000001);
	assign berr_next     = as_act && (berr_reg || berr_hit);

	// Timer registers.
	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			berr_cnt_reg <= 32'h00000000;
			berr_reg     <= 1'b0;
		end
		else
		begin
			berr_cnt_reg <= berr_cnt_next;
			berr_reg     <= berr_next;
		end
	end

	assign berr_n_o = !berr_reg;

	// ----------------------------------------
	// Refresh tick and interrupt encoding
	// ----------------------------------------
	logic tick;
	logic refresh_pend_reg;
	logic refresh_pend_next;
	logic dram_refresh_reg;
	logic ref_wr_reg;
	logic [2:0] ipl_reg;
	logic [2:0] ipl_next;
	wire  ref_wr = hit_ref && wr_strb;

	ccglue_tick #(
		.PERIOD (REFRESH_PER)
	) u_tick (
		.clk_i     (clk_i),
		.reset_n_i (reset_n_i),
		.tick_o    (tick)
	);

	// Pending refresh request: tick sets, refresh write clears, set wins.
	assign refresh_pend_next = tick || (refresh_pend_reg && !ref_wr);

	// Highest-priority encoder over all sources.
	function automatic logic [2:0] enc_level(input logic [IRQ_N-1:0] src, input logic ref_p);
		logic [2:0] lv;
		lv = ref_p ? ccglue_pkg::IPL_REFRESH : ccglue_pkg::IPL_NONE;
		for (int i = 0; i < IRQ_N; i++)
			if (src[i] && (3'(i + 1) > lv))
				lv = 3'(i + 1);
		return lv;
	endfunction

	assign ipl_next = enc_level(irq_i, refresh_pend_reg);

	// Interrupt and refresh registers; a long write still gives only one refresh pulse.
	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			refresh_pend_reg <= 1'b0;
			dram_refresh_reg <= 1'b0;
			ref_wr_reg       <= 1'b0;
			ipl_reg          <= ccglue_pkg::IPL_NONE;
		end
		else
		begin
			refresh_pend_reg <= refresh_pend_next;
			ref_wr_reg       <= ref_wr;
			dram_refresh_reg <= ref_wr && !ref_wr_reg;
			ipl_reg          <= ipl_next;
		end
	end

	assign ipl_n_o        = ~ipl_reg;
	assign dram_refresh_o = dram_refresh_reg;

	// ----------------------------------------
	// Output latch and power-fail warning
	// ----------------------------------------
	logic [7:0] latch_reg;
	logic [7:0] latch_next;
	logic       wdog_reg;

	// Processor writes the latch; warning bit signals serious error.
	assign latch_next = (hit_lat && wr_strb) ? wdata_i : latch_reg;

	// Latch and watchdog capture; both clear on reset.
	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			latch_reg <= ccglue_pkg::LATCH_RESET;
			wdog_reg  <= 1'b0;
		end
		else
		begin
			latch_reg <= latch_next;
			wdog_reg  <= wdog_reg || back_wdog_fail_i;
		end
	end

	wire pf_drive = latch_reg[ccglue_pkg::LATCH_PFW_BIT] || wdog_reg;
	// Open drain: only pull low, enable low while driving.
	assign power_fail_warning_o      = 1'b0;
	assign power_fail_warning_oe_n_o = !pf_drive;
	// Warning line is active low; any driver blocks the buffered SRAM.
	assign pf_now = !power_fail_warning_i || pf_drive;

	// ----------------------------------------
	// Self-test window after reset
	// ----------------------------------------
	logic [15:0] test_cnt_reg;
	wire         test_busy = (test_cnt_reg != 16'(TEST_LEN));

	// Counts once after each reset release.
	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			test_cnt_reg <= 16'h0000;
		else if (test_busy)
			test_cnt_reg <= test_cnt_reg + 16'h0001;
	end

	assign self_test_busy_o = test_busy;
endmodule

// ### src/ccglue_pkg.sv
// Package of constants for the processor card glue logic.
package ccglue_pkg;

	// ----------------------------------------
	// Clock and timing
	// ----------------------------------------
	localparam int unsigned CLK_HZ          = 40000000;
	// Refresh tick period in nanoseconds (3.2768 ms).
	localparam int unsigned REFRESH_NS      = 3276800;
	localparam int unsigned REFRESH_CYCLES  = REFRESH_NS / (1000000000 / CLK_HZ);
	// Default bus-error timeout in cycles.
	localparam int unsigned BERR_CYCLES     = 256;
	// Self-test length in cycles after reset.
	localparam int unsigned SELFTEST_CYCLES = 64;

	// ----------------------------------------
	// Address map (upper address nibble selects the region)
	// ----------------------------------------
	localparam logic [3:0] REG_BOOT    = 4'h0;
	localparam logic [3:0] REG_SRAM32  = 4'h1;
	localparam logic [3:0] REG_SRAM8   = 4'h2;
	localparam logic [3:0] REG_IO      = 4'hE;
	localparam logic [3:0] REG_BACK    = 4'hF;
	// Offsets inside the I/O region.
	localparam logic [27:0] IO_LATCH   = 28'h0000000;
	localparam logic [27:0] IO_REFRESH = 28'h0000010;
	// Position of the warning bit in the output latch.
	localparam int unsigned LATCH_PFW_BIT = 0;
	localparam logic [7:0]  LATCH_RESET   = 8'h00;
	// Byte-wide bank number field position.
	localparam int unsigned BANK_LSB      = 18;

	// ----------------------------------------
	// Interrupt levels
	// ----------------------------------------
	localparam logic [2:0] IPL_REFRESH = 3'h6;
	localparam logic [2:0] IPL_NONE    = 3'h0;

endpackage

// ### src/ccglue_tick.sv
// Periodic tick divider used for the refresh interrupt.
`timescale 1ns/1ps
module ccglue_tick #(
	parameter int unsigned PERIOD = ccglue_pkg::REFRESH_CYCLES
) (
	// Clock and reset
	input  wire logic clk_i,
	input  wire logic reset_n_i,
	// Tick output
	output logic      tick_o
);
	logic [31:0] cnt_reg;
	logic [31:0] cnt_next;
	logic        tick_reg;
	wire         wrap = (cnt_reg == 32'(PERIOD - 1));

	// Counter next value.
	assign cnt_next = wrap ? 32'h00000000 : cnt_reg + 32'h00000001;

	// Count and pulse once per period.
	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			cnt_reg  <= 32'h00000000;
			tick_reg <= 1'b0;
		end
		else
		begin
			cnt_reg  <= cnt_next;
			tick_reg <= wrap;
		end
	end

	assign tick_o = tick_reg;
endmodule

// ### testbench/ccglue_assertions.sv
// Concurrent checks on the glue logic ports.
`timescale 1ns/1ps
module ccglue_assertions #(
	parameter int unsigned BERR_TIMEOUT = 16
) (
	// Clock, reset and processor bus
	input wire logic        clk_i,
	input wire logic        reset_n_i,
	input wire logic [31:0] addr_i,
	input wire logic [7:0]  wdata_i,
	input wire logic        as_n_i,
	input wire logic        ds_n_i,
	input wire logic        rw_i,
	input wire logic        dsack_n_o,
	input wire logic        berr_n_o,
	// Targets and warning line
	input wire logic        back_ack_n_i,
	input wire logic        back_cs_n_o,
	input wire logic        back_wdog_fail_i,
	input wire logic        sram32_cs_n_o,
	input wire logic        dram_refresh_o,
	input wire logic        power_fail_warning_i,
	input wire logic        power_fail_warning_oe_n_o
);
	logic [15:0] as_cnt_reg;
	logic        io_wr;
	logic        back_hit;

	// Write cycle and backplane region seen by the processor.
	assign io_wr    = !as_n_i && !ds_n_i && !rw_i;
	assign back_hit = !as_n_i && addr_i[31:28] == 4'hF;

	// Counts cycles with the address strobe held low.
	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i) as_cnt_reg <= 16'h0000;
		else if (as_n_i) as_cnt_reg <= 16'h0000;
		else as_cnt_reg <= as_cnt_reg + 16'h0001;
	end

	default clocking @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);

	a_back_select: assert property (back_hit |-> !back_cs_n_o)
		else $error("backplane select missing");
	a_back_ack: assert property (back_hit |-> dsack_n_o == back_ack_n_i)
		else $error("backplane ack not passed through");
	a_sram_block: assert property (!power_fail_warning_i |-> sram32_cs_n_o)
		else $error("sram selected during power fail");
	a_berr_early: assert property (!berr_n_o && !as_n_i |-> as_cnt_reg >= 16'(BERR_TIMEOUT))
		else $error("bus error before timeout");
	a_berr_late: assert property (!as_n_i && as_cnt_reg == 16'(BERR_TIMEOUT + 1) |-> !berr_n_o)
		else $error("bus error missing after timeout");
	a_berr_release: assert property ($rose(as_n_i) |=> berr_n_o)
		else $error("bus error not released");
	a_refresh_pulse: assert property ($rose(io_wr && addr_i == 32'hE0000010) |=> dram_refresh_o ##1 !dram_refresh_o)
		else $error("refresh pulse wrong");
	a_latch_set: assert property (io_wr && addr_i == 32'hE0000000 && wdata_i[0] |=> !power_fail_warning_oe_n_o)
		else $error("warning not driven from latch");
	a_wdog_warn: assert property (back_wdog_fail_i |-> ##[1:3] !power_fail_warning_oe_n_o)
		else $error("watchdog failure not warned");
	a_latch_reset: assert property ($rose(reset_n_i) |-> power_fail_warning_oe_n_o)
		else $error("warning not cleared by reset");
endmodule

// ### testbench/ccglue_back_model.sv
// Backplane interface chip model: acknowledges a selected strobe after a set delay.
`timescale 1ns/1ps
module ccglue_back_model (
	// Clock and reset
	input wire logic       clk_i,
	input wire logic       reset_n_i,
	// Glue side
	input wire logic       cs_n_i,
	input wire logic       strb_n_i,
	input wire logic [1:0] delay_i,
	output logic           ack_n_o
);
	logic [1:0] wait_reg;

	// Counts a selected strobe; the pulled-up ack goes high as soon as it is deselected.
	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i) wait_reg <= 2'h0;
		else if (cs_n_i || strb_n_i) wait_reg <= 2'h0;
		else if (wait_reg != delay_i) wait_reg <= wait_reg + 2'h1;
	end
	assign ack_n_o = cs_n_i || strb_n_i || wait_reg != delay_i;
endmodule

// ### testbench/ccglue_top_tb_top.sv
// Self-checking testbench of the processor card glue logic.
`timescale 1ns/1ps
module ccglue_top_tb_top;
	localparam int BT = 16;
	localparam int RP = 50;
	localparam int TL = 8;
	logic clk_i, reset_n_i, as_n_i, ds_n_i, rw_i, dsack_n_o, berr_n_o, back_cs_n_o, back_strb_n_o;
	logic back_ack_n_i, back_wdog_fail_i, boot_cs_n_o, sram32_cs_n_o, mem_oe_n_o, mem_we_n_o;
	logic dram_refresh_o, power_fail_warning_i, power_fail_warning_o, power_fail_warning_oe_n_o;
	logic self_test_busy_o, conv_n;
	logic [31:0] addr_i;
	logic [7:0]  wdata_i;
	logic [5:0]  irq_i;
	logic [3:0]  sram8_cs_n_o;
	logic [2:0]  ipl_n_o;
	logic [1:0]  dly;
	logic [3:0]  rg [4] = '{4'h0, 4'h1, 4'h2, 4'hF};
	int failures = 0;
	int checks_done = 0;

	ccglue_top #(.BERR_TIMEOUT(BT), .REFRESH_PER(RP), .TEST_LEN(TL)) u_ccglue_top (
		.clk_i(clk_i), .reset_n_i(reset_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
		.as_n_i(as_n_i), .ds_n_i(ds_n_i), .rw_i(rw_i), .dsack_n_o(dsack_n_o), .berr_n_o(berr_n_o),
		.ipl_n_o(ipl_n_o), .irq_i(irq_i), .back_cs_n_o(back_cs_n_o), .back_strb_n_o(back_strb_n_o),
		.back_ack_n_i(back_ack_n_i), .back_wdog_fail_i(back_wdog_fail_i), .boot_cs_n_o(boot_cs_n_o),
		.sram32_cs_n_o(sram32_cs_n_o), .sram8_cs_n_o(sram8_cs_n_o), .mem_oe_n_o(mem_oe_n_o),
		.mem_we_n_o(mem_we_n_o), .dram_refresh_o(dram_refresh_o), .power_fail_warning_i(power_fail_warning_i),
		.power_fail_warning_o(power_fail_warning_o), .power_fail_warning_oe_n_o(power_fail_warning_oe_n_o),
		.self_test_busy_o(self_test_busy_o));
	ccglue_back_model u_ccglue_back_model (.clk_i(clk_i), .reset_n_i(reset_n_i), .cs_n_i(back_cs_n_o),
		.strb_n_i(back_strb_n_o), .delay_i(dly), .ack_n_o(back_ack_n_i));

	// Open-drain warning line: the converter and the glue may both pull it low.
	assign power_fail_warning_i = conv_n & (power_fail_warning_oe_n_o | power_fail_warning_o);

	// Clock source, 25 ns period.
	initial
	begin
		clk_i = 1'b0;
		forever #12.5 clk_i = ~clk_i;
	end

	task automatic chk(input logic [7:0] s, input logic [7:0] e);
	begin
		checks_done++;
		if (s !== e)
		begin
			failures++;
			$display("FAIL t=%0t seen %h expected %h", $time, s, e);
		end
	end
	endtask

	// Selects {boot, sram32, sram8[3:0], backplane} expected for an address.
	function automatic logic [6:0] exp_sel(input logic [31:0] a, input logic blk);
	begin
		case (a[31:28])
			4'h0: return 7'h3F;
			4'h1: return blk ? 7'h7F : 7'h5F;
			4'h2: return blk ? 7'h7F : {2'h3, ~(4'h1 << a[19:18]), 1'h1};
			4'hF: return 7'h7E;
			default: return 7'h7F;
		endcase
	end
	endfunction

	function automatic logic [2:0] exp_ipl(input logic [5:0] q);
		logic [2:0] l;
	begin
		l = 3'h0;
		for (int i = 0; i < 6; i++) if (q[i]) l = 3'(i + 1);
		return ~l;
	end
	endfunction

	// One processor cycle: strobes held until ack or bus error is sampled.
	task automatic bus(input logic [31:0] a, input logic w, input logic [7:0] d,
		output logic k, output logic [6:0] s, output int n);
	begin
		addr_i <= a;
		wdata_i <= d;
		rw_i <= ~w;
		as_n_i <= 1'b0;
		ds_n_i <= 1'b0;
		n = 0;
		do
		begin
			@(posedge clk_i);
			n++;
		end
		while (dsack_n_o !== 1'b0 && berr_n_o !== 1'b0 && n < 60);
		k = dsack_n_o;
		s = {boot_cs_n_o, sram32_cs_n_o, sram8_cs_n_o, back_cs_n_o};
		chk(8'({mem_oe_n_o, mem_we_n_o}), {6'h00, w, ~w});
		as_n_i <= 1'b1;
		ds_n_i <= 1'b1;
		@(posedge clk_i);
	end
	endtask

	// Reset pulse, then the self-test window and the cleared warning.
	task automatic rst();
		int n;
	begin
		reset_n_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		reset_n_i <= 1'b1;
		n = 0;
		while (self_test_busy_o === 1'b1 && n < 40)
		begin
			@(posedge clk_i);
			n++;
		end
		chk(8'(n >= TL - 1 && n <= TL + 1), 8'h01);
		chk(8'(power_fail_warning_oe_n_o), 8'h01);
		$display("test reset done");
	end
	endtask

	task automatic results();
	begin
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	end
	endtask

	// Main sequence.
	initial
	begin
		logic k;
		logic [6:0] s;
		int n;
		logic [31:0] a;
		time t0;
		reset_n_i = 1'b0;
		{as_n_i, ds_n_i, rw_i, conv_n} = 4'hF;
		{addr_i, wdata_i, irq_i, back_wdog_fail_i, dly} = '0;
		void'($urandom(71));
		rst();
		for (int i = 0; i < 28; i++)
		begin
			a = $urandom;
			a[31:28] = rg[i % 4];
			a[19:18] = 2'(i / 4);
			dly <= 2'($urandom);
			bus(a, 1'($urandom), 8'h00, k, s, n);
			chk(8'(k), 8'h00);
			chk(8'(s), 8'(exp_sel(a, 1'b0)));
		end
		bus({4'h5, 28'($urandom)}, 1'b0, 8'h00, k, s, n);
		chk(8'(n >= BT + 1 && n <= BT + 2), 8'h01);
		@(posedge clk_i);
		chk(8'(berr_n_o), 8'h01);
		$display("test decode done");
		// Clear the request left from the decode test, so that the next tick seen is a fresh one.
		do
		begin
			bus(32'hE0000010, 1'b1, 8'h00, k, s, n);
			@(posedge clk_i);
		end
		while (ipl_n_o === ~ccglue_pkg::IPL_REFRESH);
		for (int j = 0; j < 2; j++)
		begin
			n = 0;
			while (ipl_n_o !== ~ccglue_pkg::IPL_REFRESH && n < 200)
			begin
				@(posedge clk_i);
				n++;
			end
			if (j == 1) chk(8'((($time - t0) / 25) == RP), 8'h01);
			t0 = $time;
			bus(32'hE0000010, 1'b1, 8'h00, k, s, n);
			// The level register follows the cleared request one cycle later.
			@(posedge clk_i);
			chk(8'(ipl_n_o), 8'h07);
			for (int i = 0; i < 7; i++)
			begin
				irq_i <= (i == 6) ? 6'h00 : (6'h01 << i) | 6'($urandom % (1 << i));
				repeat (2) @(posedge clk_i);
				chk(8'(ipl_n_o), 8'(exp_ipl(irq_i)));
			end
		end
		$display("test refresh done");
		conv_n <= 1'b0;
		repeat (3) @(posedge clk_i);
		a = {4'h2, 28'($urandom)};
		bus(a, 1'b0, 8'h00, k, s, n);
		chk({k, s}, {1'b1, exp_sel(a, 1'b1)});
		conv_n <= 1'b1;
		for (int i = 0; i < 3; i++)
		begin
			bus(32'hE0000000, 1'b1, 8'(i != 1), k, s, n);
			chk(8'(power_fail_warning_oe_n_o), 8'(i == 1));
		end
		// Latch bit still set: the wide SRAM bank must stay blocked.
		a = {4'h1, 28'($urandom)};
		bus(a, 1'($urandom), 8'h00, k, s, n);
		chk({k, s}, {1'b1, exp_sel(a, 1'b1)});
		chk(8'(power_fail_warning_o), 8'h00);
		rst();
		back_wdog_fail_i <= 1'b1;
		@(posedge clk_i);
		back_wdog_fail_i <= 1'b0;
		repeat (3) @(posedge clk_i);
		chk(8'(power_fail_warning_oe_n_o), 8'h00);
		rst();
		$display("test power fail done");
		results();
	end

	// Hang guard.
	initial
	begin
		#(25 * 4000);
		failures++;
		results();
	end
endmodule

bind ccglue_top ccglue_assertions #(.BERR_TIMEOUT(BERR_TIMEOUT)) u_ccglue_assertions (
	.clk_i(clk_i), .reset_n_i(reset_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .as_n_i(as_n_i),
	.ds_n_i(ds_n_i), .rw_i(rw_i), .dsack_n_o(dsack_n_o), .berr_n_o(berr_n_o), .back_ack_n_i(back_ack_n_i),
	.back_cs_n_o(back_cs_n_o), .back_wdog_fail_i(back_wdog_fail_i), .sram32_cs_n_o(sram32_cs_n_o),
	.dram_refresh_o(dram_refresh_o), .power_fail_warning_i(power_fail_warning_i),
	.power_fail_warning_oe_n_o(power_fail_warning_oe_n_o));
